//--- rtl/bhc_pkg.sv
`default_nettype none
package bhc_pkg;
  // ==========================================================
  // Register map (byte offsets, one 32-bit word each)
  localparam logic [5:0] OFS_CTRL   = 6'h00;
  localparam logic [5:0] OFS_PERIOD = 6'h04;
  localparam logic [5:0] OFS_CMP0   = 6'h08;
  localparam logic [5:0] OFS_STATUS = 6'h20;
  localparam int         NUM_SW     = 6;

  // ==========================================================
  // Control word fields: high byte 15..8, low byte 7..0
  localparam int B_EXT_SEL = 15;
  localparam int B_ZF      = 14;
  localparam int B_ZE      = 13;
  localparam int B_MSI     = 10;
  localparam int B_PMF     = 9;
  localparam int B_PME     = 8;
  localparam int B_BUF     = 7;
  localparam int B_STOP    = 6;
  localparam int B_MODE    = 5;
  localparam int B_CLR     = 4;
  localparam int B_DIV     = 0;

  // Status word fields
  localparam int ST_HALL = 16;
  localparam int ST_DOWN = 19;
  localparam int ST_OUT  = 20;

  // ==========================================================
  // Reset values
  localparam logic [15:0] CTRL_RST   = 16'h0040;
  localparam logic [15:0] PERIOD_RST = 16'hffff;
  localparam logic [15:0] CMP_RST    = 16'h0000;

  // ==========================================================
  // Timing: base tick in 12.5 ns units so 62.5 ns is exact
  localparam int CLK_PS     = 25000;
  localparam int TICK_PS    = 62500;
  localparam int UNIT_PS    = 12500;
  localparam int CLK_UNITS  = CLK_PS / UNIT_PS;
  localparam int TICK_UNITS = TICK_PS / UNIT_PS;

  typedef struct packed {
    logic [15:0]            cnt;
    logic                   down;
    logic [15:0]            per_buf;
    logic [15:0]            per;
    logic [NUM_SW-1:0][15:0] cmp;
    logic [15:0]            ctl;
    logic                   ack;
    logic [31:0]            rdata;
    logic [NUM_SW-1:0]      outs;
    logic                   ext_q;
  } bhc_state_s;
endpackage : bhc_pkg
`default_nettype wire

//--- rtl/bhc_sync.sv
`default_nettype none
module bhc_sync #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rst_n,
  // Asynchronous levels in, synchronised levels out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] m1;
    logic [W-1:0] m2;
  } bhc_sync_s;

  bhc_sync_s s_q;
  bhc_sync_s s_d;

  always_comb begin
    s_d    = s_q;
    s_d.m1 = d;
    s_d.m2 = s_q.m1;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign q = s_q.m2;
endmodule : bhc_sync
`default_nettype wire

//--- rtl/bhc_tick_div.sv
`default_nettype none
module bhc_tick_div
  import bhc_pkg::*;
#(
  parameter int DIV_W = 4
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst_n,
  // Control
  input  wire logic             run,
  input  wire logic [DIV_W-1:0] div,
  // One-cycle tick enable
  output logic                  tick
);
  localparam int PRE_W = 2 ** DIV_W;

  typedef struct packed {
    logic [3:0]       acc;
    logic [PRE_W-1:0] pre;
    logic             tick;
  } bhc_div_s;

  bhc_div_s s_q;
  bhc_div_s s_d;

  // Base ticks alternate 2 and 3 clocks: exact 62.5 ns on average
  always_comb begin
    s_d      = s_q;
    s_d.tick = 1'b0;
    if (!run) begin
      s_d.acc = '0;
      s_d.pre = '0;
    end else if (s_q.acc + 4'(CLK_UNITS) >= 4'(TICK_UNITS)) begin
      s_d.acc = s_q.acc + 4'(CLK_UNITS) - 4'(TICK_UNITS);
      // At or past the end: a smaller divider must not stall a full wrap
      if (s_q.pre >= (PRE_W'(1) << div) - PRE_W'(1)) begin
        s_d.pre  = '0;
        s_d.tick = 1'b1;
      end else begin
        s_d.pre = s_q.pre + PRE_W'(1);
      end
    end else begin
      s_d.acc = s_q.acc + 4'(CLK_UNITS);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;
endmodule : bhc_tick_div
`default_nettype wire

//--- rtl/bhc_top.sv
// Added by the designer: the Avalon-MM slave port and the register addresses.
`default_nettype none
module bhc_top
  import bhc_pkg::*;
#(
  parameter int DIV_W = 4
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Avalon-MM slave
  input  wire logic [5:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Hall sensors and external count clock
  input  wire logic        hall_a,
  input  wire logic        hall_b,
  input  wire logic        hall_c,
  input  wire logic        ext_count_clk,
  // Bridge switches
  output logic             phase_a_top_out,
  output logic             phase_a_bottom_out,
  output logic             phase_b_top_out,
  output logic             phase_b_bottom_out,
  output logic             phase_c_top_out,
  output logic             phase_c_bottom_out,
  // Interrupt requests
  output logic             zero_hit_irq,
  output logic             period_match_irq
);
  // ==========================================================
  // Input synchronisers and tick source
  logic [3:0] pins_s;
  logic [2:0] hall_s;
  logic       ext_s;
  logic       int_tick;
  logic       tick;
  logic       stopped;

  bhc_sync #(
    .W (4)
  ) u_sync (
    .clock (clock),
    .rst_n (rst_n),
    .d     ({ext_count_clk, hall_c, hall_b, hall_a}),
    .q     (pins_s)
  );

  assign hall_s = pins_s[2:0];
  assign ext_s  = pins_s[3];

  bhc_state_s s_q;
  bhc_state_s s_d;

  assign stopped = s_q.ctl[B_STOP];

  bhc_tick_div #(
    .DIV_W (DIV_W)
  ) u_div (
    .clock (clock),
    .rst_n (rst_n),
    .run   (!stopped),
    .div   (s_q.ctl[B_DIV +: DIV_W]),
    .tick  (int_tick)
  );

  // Zero selects the divided internal tick; one counts pin edges
  assign tick = s_q.ctl[B_EXT_SEL] ? (ext_s && !s_q.ext_q)
                                   : int_tick;

  // ==========================================================
  // Bus decode
  logic       req;
  logic       wr_go;
  logic [3:0] idx;
  logic       is_cmp;
  logic [2:0] cmp_idx;

  assign req         = read || write;
  assign waitrequest = req && !s_q.ack;
  assign wr_go       = write && s_q.ack;
  assign idx         = address[5:2];
  assign is_cmp      = (address >= OFS_CMP0) && (address < OFS_STATUS);
  assign cmp_idx     = 3'(idx - OFS_CMP0[5:2]);

  // ==========================================================
  // Commutation from the hall code
  logic             hall_ok;
  logic [NUM_SW-1:0] comm;
  logic [NUM_SW-1:0] gate;

  // Each hall bit is a plain one or zero; 000 and 111 are no sector
  assign hall_ok = (hall_s != 3'h0) && (hall_s != 3'h7);

  always_comb begin
    for (int p = 0; p < 3; p++) begin
      // Top on where this phase detects and the next does not;
      // this leaves one top and one bottom per sector
      comm[2*p]   = hall_s[p] && !hall_s[(p+1)%3];
      comm[2*p+1] = !hall_s[p] && hall_s[(p+1)%3];
    end
    for (int i = 0; i < NUM_SW; i++) begin
      gate[i] = s_q.cnt < s_q.cmp[i];
    end
  end

  // ==========================================================
  // State update
  logic        ev_zero;
  logic        ev_match;
  logic [15:0] wd;
  logic [31:0] rd;

  always_comb begin
    s_d      = s_q;
    ev_zero  = 1'b0;
    ev_match = 1'b0;
    s_d.ack  = req && !s_q.ack;
    s_d.ext_q = ext_s;
    wd       = writedata[15:0];
    rd       = 32'h0;

    // Counter
    if (tick && !stopped) begin
      if (!s_q.ctl[B_MODE]) begin
        if (s_q.cnt >= s_q.per) begin
          s_d.cnt  = 16'h0;
          ev_match = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt + 16'h1;
        end
        s_d.down = 1'b0;
      end else if (!s_q.down) begin
        if (s_q.cnt >= s_q.per) begin
          s_d.down = 1'b1;
          s_d.cnt  = s_q.cnt - 16'h1;
          ev_match = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt + 16'h1;
        end
      end else begin
        if (s_q.cnt == 16'h0) begin
          s_d.down = 1'b0;
          s_d.cnt  = 16'h1;
        end else begin
          s_d.cnt = s_q.cnt - 16'h1;
        end
      end
      ev_zero = (s_d.cnt == 16'h0) && (s_q.cnt != 16'h0);
    end

    // Period: straight through, or held until the zero point
    if (!s_q.ctl[B_BUF] || ev_zero) begin
      s_d.per = s_q.per_buf;
    end

    // Register writes take effect at the accepting edge
    if (wr_go) begin
      if (address == OFS_CTRL) begin
        if (byteenable[1]) begin
          s_d.ctl[15:8] = wd[15:8];
          // Flags only clear on zero; a one leaves them alone
          s_d.ctl[B_ZF]  = s_q.ctl[B_ZF] && wd[B_ZF];
          s_d.ctl[B_PMF] = s_q.ctl[B_PMF] && wd[B_PMF];
        end
        if (byteenable[0]) begin
          s_d.ctl[7:0]   = wd[7:0];
          s_d.ctl[B_CLR] = 1'b0;
          if (wd[B_CLR]) begin
            s_d.cnt  = 16'h0;
            s_d.down = 1'b0;
          end
        end
      end else if (address == OFS_PERIOD) begin
        if (byteenable[0]) s_d.per_buf[7:0]  = wd[7:0];
        if (byteenable[1]) s_d.per_buf[15:8] = wd[15:8];
      end else if (is_cmp && address[1:0] == 2'h0) begin
        if (byteenable[0]) s_d.cmp[cmp_idx][7:0]  = wd[7:0];
        if (byteenable[1]) s_d.cmp[cmp_idx][15:8] = wd[15:8];
      end
    end

    // Events win over a clearing write in the same cycle
    if (ev_zero) begin
      s_d.ctl[B_ZF] = 1'b1;
    end
    if (ev_match) begin
      s_d.ctl[B_PMF] = 1'b1;
    end

    // Read data captured on the wait cycle
    if (address == OFS_CTRL) begin
      rd[15:0] = s_q.ctl;
    end else if (address == OFS_PERIOD) begin
      rd[15:0] = s_q.per_buf;
    end else if (is_cmp && address[1:0] == 2'h0) begin
      rd[15:0] = s_q.cmp[cmp_idx];
    end else if (address == OFS_STATUS) begin
      rd[15:0]           = s_q.cnt;
      rd[ST_HALL +: 3]   = hall_s;
      rd[ST_DOWN]        = s_q.down;
      rd[ST_OUT +: NUM_SW] = s_q.outs;
    end
    if (read && !s_q.ack) begin
      s_d.rdata = rd;
    end

    // Switch outputs, registered
    s_d.outs = hall_ok ? (comm & gate) : '0;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q         <= '0;
      s_q.ctl     <= CTRL_RST;
      s_q.per     <= PERIOD_RST;
      s_q.per_buf <= PERIOD_RST;
      s_q.cmp     <= {NUM_SW{CMP_RST}};
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs
  assign readdata           = s_q.rdata;
  assign phase_a_top_out    = s_q.outs[0];
  assign phase_a_bottom_out = s_q.outs[1];
  assign phase_b_top_out    = s_q.outs[2];
  assign phase_b_bottom_out = s_q.outs[3];
  assign phase_c_top_out    = s_q.outs[4];
  assign phase_c_bottom_out = s_q.outs[5];
  assign zero_hit_irq     = s_q.ctl[B_ZF] && s_q.ctl[B_ZE];
  assign period_match_irq = s_q.ctl[B_PMF] && s_q.ctl[B_PME];

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  logic [2:0] tops;
  logic [2:0] bots;
  assign tops = {s_q.outs[4], s_q.outs[2], s_q.outs[0]};
  assign bots = {s_q.outs[5], s_q.outs[3], s_q.outs[1]};

  a_hall_bad_off: assert property (
    !hall_ok |=> s_q.outs == '0)
    else $error("outputs on with invalid hall code");

  a_top_needs_hall: assert property (
    s_q.outs[0] |-> $past(hall_s[0]) && !$past(hall_s[1]))
    else $error("phase a top on without hall detect");

  a_two_coils: assert property (
    s_q.outs != '0 |-> $countones(tops) <= 1 && $countones(bots) <= 1)
    else $error("more than two coils driven");

  a_gate_by_cmp: assert property (
    s_q.outs[1] |-> $past(s_q.cnt) < $past(s_q.cmp[1]))
    else $error("output on past its compare value");

  a_stop_holds: assert property (
    stopped && !wr_go |=> $stable(s_q.cnt))
    else $error("counter moved while stopped");

  a_clear_zero: assert property (
    wr_go && address == OFS_CTRL && byteenable[0] && writedata[B_CLR]
    |=> s_q.cnt == 16'h0 && !s_q.ctl[B_CLR])
    else $error("counter clear failed");

  a_up_wrap: assert property (
    tick && !stopped && !s_q.ctl[B_MODE] && s_q.cnt >= s_q.per && !wr_go
    |=> s_q.cnt == 16'h0 ##0 s_q.ctl[B_PMF])
    else $error("up count did not wrap at period");

  a_peak_turn: assert property (
    tick && !stopped && s_q.ctl[B_MODE] && !s_q.down
    && s_q.cnt >= s_q.per && s_q.per != 16'h0 && !wr_go
    |=> s_q.down && s_q.cnt == $past(s_q.cnt) - 16'h1)
    else $error("no turn at peak");

  a_match_irq: assert property (
    ev_match |=> s_q.ctl[B_PMF] ##0 (period_match_irq == s_q.ctl[B_PME]))
    else $error("match flag or request wrong");

  a_bot_no_hall: assert property (
    s_q.outs[1] |-> !$past(hall_s[0]) && $past(hall_s[1]))
    else $error("phase a bottom on while hall detects");

  a_up_step: assert property (
    tick && !stopped && !s_q.ctl[B_MODE] && s_q.cnt < s_q.per && !wr_go
    |=> s_q.cnt == $past(s_q.cnt) + 16'h1)
    else $error("up count did not step by one");

  a_per_held: assert property (
    s_q.ctl[B_BUF] && !ev_zero |=> $stable(s_q.per))
    else $error("buffered period changed off the zero point");

  a_pmf_clear: assert property (
    wr_go && address == OFS_CTRL && byteenable[1] && !writedata[B_PMF]
    && !ev_match |=> !s_q.ctl[B_PMF])
    else $error("match flag not cleared by zero write");

  a_zf_clear: assert property (
    wr_go && address == OFS_CTRL && byteenable[1] && !writedata[B_ZF]
    && !ev_zero |=> !s_q.ctl[B_ZF])
    else $error("zero flag not cleared by zero write");

  a_zero_flag: assert property (
    ev_zero |=> s_q.ctl[B_ZF] ##0 (zero_hit_irq == s_q.ctl[B_ZE]))
    else $error("zero flag or request wrong");

  a_bus_wait: assert property (
    req && waitrequest |=> !waitrequest)
    else $error("waitrequest held over one cycle");

  c_peak: cover property (ev_match && s_q.ctl[B_MODE]);
  c_zero: cover property (ev_zero ##1 zero_hit_irq);
  c_drive: cover property (hall_ok ##2 s_q.outs != '0);
  c_read: cover property (read && !waitrequest);
endmodule : bhc_top
`default_nettype wire

//--- verification/bhc_motor_model.sv
`default_nettype none
module bhc_motor_model (
  // Clock
  input  wire logic       clock,
  // Rotor position asked for by the bench
  input  wire logic [2:0] code,
  // Hall sensor lines
  output logic            hall_a,
  output logic            hall_b,
  output logic            hall_c,
  // Bridge switches and shoot-through alarm
  input  wire logic [5:0] sw,
  output logic            short_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Hall sensors
  initial {hall_c, hall_b, hall_a} = 3'h0;
  always @(posedge clock) begin
    {hall_c, hall_b, hall_a} <= code;
  end
  // ==========================================================
  // Bridge: top and bottom of one leg together would short the supply
  initial short_seen = 1'b0;
  always @(posedge clock) begin
    for (int p = 0; p < 3; p++)
      if (sw[2*p] && sw[2*p+1]) short_seen <= 1'b1;
  end
endmodule : bhc_motor_model
`default_nettype wire

//--- verification/tb_bldc_hall_commutation_timer.sv
`default_nettype none
module tb_bldc_hall_commutation_timer;
  import bhc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [5:0]  address = 6'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        hall_a, hall_b, hall_c, short_seen;
  logic [5:0]  sw;
  logic        zero_hit_irq, period_match_irq;
  logic [2:0]  code = 3'h0;
  logic [3:0]  be = 4'h3;
  logic        ext_pin = 1'b0;
  logic [31:0] rv;
  logic [15:0] c1, mx;
  logic        sd, watch = 1'b0, seen_zh = 1'b0, seen_pm = 1'b0;
  int          mismatches = 0;
  int          n_tests = 0;
  int          seed = 32'hce11;

  always #12.5 clock = ~clock;

  bhc_top bhc_top_i (.clock(clock), .rst_n(rst_n), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .byteenable(be), .readdata(readdata), .waitrequest(waitrequest),
    .hall_a(hall_a), .hall_b(hall_b), .hall_c(hall_c),
    .ext_count_clk(ext_pin), .phase_a_top_out(sw[0]),
    .phase_a_bottom_out(sw[1]), .phase_b_top_out(sw[2]),
    .phase_b_bottom_out(sw[3]), .phase_c_top_out(sw[4]),
    .phase_c_bottom_out(sw[5]), .zero_hit_irq(zero_hit_irq),
    .period_match_irq(period_match_irq));

  bhc_motor_model bhc_motor_model_i (.clock(clock), .code(code),
    .hall_a(hall_a), .hall_b(hall_b), .hall_c(hall_c), .sw(sw),
    .short_seen(short_seen));

  // ==========================================================
  // Checking and closing
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tally_and_finish;
    if (mismatches == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  // ==========================================================
  // Avalon master: hold the request until waitrequest is seen low
  task automatic bus(input logic wr, input logic [5:0] a,
                     input logic [15:0] d);
    logic w;
    w = 1'b1;
    @(posedge clock);
    read      <= ~wr;
    write     <= wr;
    address   <= a;
    writedata <= {16'h0, d};
    // Waitrequest and read data are taken at the same rising edge
    for (int i = 0; i < 20 && w; i++) begin
      @(posedge clock);
      w  = waitrequest;
      rv = readdata;
    end
    read  <= 1'b0;
    write <= 1'b0;
    if (w) begin
      mismatches++;
      tally_and_finish();
    end
  endtask : bus

  // Irq levels are sampled on the edge, before that edge's updates land
  always @(posedge clock) begin
    if (watch) begin
      seen_zh <= seen_zh | zero_hit_irq;
      seen_pm <= seen_pm | period_match_irq;
    end
  end

  // Largest count and any down phase over n status reads
  task automatic sweep(input int n);
    mx = 16'h0;
    sd = 1'b0;
    repeat (n) begin
      bus(1'b0, OFS_STATUS, 16'h0);
      if (rv[15:0] > mx) mx = rv[15:0];
      sd = sd | rv[ST_DOWN];
    end
  endtask : sweep

  // ==========================================================
  // Expected switch pattern for one hall code
  function automatic logic [5:0] exp_sw(input logic [2:0] h);
    logic [5:0] r;
    r = 6'h00;
    if (h != 3'h0 && h != 3'h7)
      for (int p = 0; p < 3; p++) begin
        r[2*p]   = h[p] & ~h[(p+1)%3];
        r[2*p+1] = ~h[p] & h[(p+1)%3];
      end
    return r;
  endfunction : exp_sw

  task automatic hall_chk(input logic [2:0] h, input logic [5:0] m);
    @(posedge clock);
    code <= h;
    repeat (6) @(posedge clock);
    chk({26'h0, sw}, {26'h0, exp_sw(h) & m});
  endtask : hall_chk

  // Counter advance over a fixed gap, checked against a window
  task automatic rate(input logic [15:0] ctl, input int gap,
                      input int lo, input int hi);
    bus(1'b1, OFS_CTRL, ctl);
    bus(1'b0, OFS_STATUS, 16'h0);
    c1 = rv[15:0];
    repeat (gap) @(posedge clock);
    bus(1'b0, OFS_STATUS, 16'h0);
    c1 = rv[15:0] - c1;
    chk({31'h0, c1 >= lo && c1 <= hi}, 32'h1);
  endtask : rate

  // ==========================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    bus(1'b0, OFS_CTRL, 16'h0);
    chk(rv, {16'h0, CTRL_RST});
    bus(1'b0, OFS_PERIOD, 16'h0);
    chk(rv, {16'h0, PERIOD_RST});
    bus(1'b0, OFS_CMP0, 16'h0);
    chk(rv, {16'h0, CMP_RST});
    bus(1'b1, 6'h3c, 16'h1234);
    bus(1'b0, 6'h3c, 16'h0);
    chk(rv, 32'h0);
    // Lane pairing: a low-lane-only write keeps the high byte
    be <= 4'h1;
    bus(1'b1, OFS_PERIOD, 16'h12ab);
    be <= 4'h3;
    bus(1'b0, OFS_PERIOD, 16'h0);
    chk(rv, 32'h0000ffab);
    // Full compare windows so only the hall code decides
    for (int i = 0; i < NUM_SW; i++)
      bus(1'b1, OFS_CMP0 + 6'(4 * i), 16'hffff);
    for (int h = 0; h < 8; h++)
      hall_chk(3'(h), 6'h3f);
    repeat (12) hall_chk(3'($random(seed)), 6'h3f);
    // A zero compare value keeps phase A top off
    bus(1'b1, OFS_CMP0, 16'h0000);
    hall_chk(3'b001, 6'h3e);
    bus(1'b1, OFS_CMP0, 16'hffff);
    chk({31'h0, short_seen}, 32'h0);
    // External source: synchronised rising pin edges are counted
    bus(1'b1, OFS_CTRL, 16'h8010);
    repeat (5) begin
      repeat (4) @(posedge clock);
      ext_pin <= 1'b1;
      repeat (4) @(posedge clock);
      ext_pin <= 1'b0;
    end
    repeat (4) @(posedge clock);
    bus(1'b0, OFS_STATUS, 16'h0);
    chk({16'h0, rv[15:0]}, 32'h5);
    // Tick rate at divider 0 and 3, stop and clear
    rate(16'h0010, 100, 39, 42);
    rate(16'h0013, 200, 9, 11);
    bus(1'b1, OFS_CTRL, 16'h0040);
    rate(16'h0040, 20, 0, 0);
    bus(1'b1, OFS_CTRL, 16'h0050);
    bus(1'b0, OFS_STATUS, 16'h0);
    chk({16'h0, rv[15:0]}, 32'h0);
    // Up/down with a short period and both events enabled
    bus(1'b1, OFS_PERIOD, 16'h0008);
    watch <= 1'b1;
    bus(1'b1, OFS_CTRL, 16'h2131);
    sweep(40);
    chk({16'h0, mx}, 32'h8);
    chk({31'h0, sd}, 32'h1);
    chk({30'h0, seen_zh, seen_pm}, 32'h3);
    // Flags kept by writing one, requests masked by the enables
    bus(1'b1, OFS_CTRL, 16'h4260);
    repeat (2) @(posedge clock);
    chk({30'h0, zero_hit_irq, period_match_irq}, 32'h0);
    bus(1'b0, OFS_CTRL, 16'h0);
    chk(rv & 32'h4200, 32'h4200);
    bus(1'b1, OFS_CTRL, 16'h6360);
    repeat (2) @(posedge clock);
    chk({30'h0, zero_hit_irq, period_match_irq}, 32'h3);
    bus(1'b1, OFS_CTRL, 16'h2160);
    repeat (2) @(posedge clock);
    chk({30'h0, zero_hit_irq, period_match_irq}, 32'h0);
    bus(1'b0, OFS_CTRL, 16'h0);
    chk(rv & 32'h4200, 32'h0);
    // Buffered period: new value waits for the next bottom
    bus(1'b1, OFS_CTRL, 16'h0050);
    bus(1'b1, OFS_CTRL, 16'h00a1);
    bus(1'b1, OFS_PERIOD, 16'h0003);
    sweep(30);
    chk({16'h0, mx}, 32'h8);
    sweep(30);
    chk({16'h0, mx}, 32'h3);
    tally_and_finish();
  end
endmodule : tb_bldc_hall_commutation_timer
`default_nettype wire
